// >>> core/sysctl_pkg.sv
package sysctl_pkg;
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int IRQ_LINES = 4;
   localparam int SYNC_WIDTH = IRQ_LINES + 3;

   // bus hold and interrupt acknowledge timing, in ns, and derived cycle counts
   localparam int HOLD_FLOAT_MIN_NS = 40;
   localparam int RELEASE_DRIVE_NS = 30;
   localparam int RELEASE_GRANT_NS = 40;
   localparam int IRQ_ACKNOWLEDGE_MIN_NS = 90;
   localparam logic [3:0] HOLD_FLOAT_CYC =
      4'((HOLD_FLOAT_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [3:0] RELEASE_DRIVE_CYC =
      4'((RELEASE_DRIVE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [3:0] RELEASE_GRANT_CYC =
      4'((RELEASE_GRANT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [3:0] IRQ_ACKNOWLEDGE_MIN_CYC =
      4'((IRQ_ACKNOWLEDGE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [3:0] BURST_RETAIN_COUNT = 4'h8;

   // register map, byte addresses
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] PENDING_OFFSET = 4'h8;
   localparam int CTRL_HOLD_DISABLE_BIT = 0;
   localparam int CTRL_BURST_RETAIN_BIT = 1;
   localparam logic CTRL_HOLD_DISABLE_RESET = 1'b0;
   localparam logic CTRL_BURST_RETAIN_RESET = 1'b0;
   localparam int STATUS_GRANTED_BIT = 0;
   localparam int STATUS_FLOATED_BIT = 1;
   localparam int STATUS_REQUEST_BIT = 2;
   localparam int STATUS_IN_RESET_BIT = 3;
   localparam int STATUS_STRAP_BIT = 4;
   localparam int STATUS_IRQ_NUM_LSB = 8;

   // interrupt number of line 0; arbitrary base
   localparam logic [3:0] IRQ_NUM_BASE = 4'h4;

   // synchroniser lane positions and reset values
   localparam int SYNC_HOLD_BIT = 0;
   localparam int SYNC_RESET_BIT = 1;
   localparam int SYNC_CS_BIT = 2;
   localparam int SYNC_IRQ_LSB = 3;
   localparam logic [SYNC_WIDTH-1:0] SYNC_RESET_VAL = 7'h05;

   typedef enum logic [2:0] {
      HOLD_IDLE = 3'b000,
      HOLD_DRAIN = 3'b001,
      HOLD_FLOAT = 3'b010,
      HOLD_GRANTED = 3'b011,
      HOLD_RELEASE = 3'b100
   } hold_state_e;

   typedef enum logic [1:0] {
      SVC_IDLE = 2'b00,
      SVC_WAIT = 2'b01,
      SVC_ACK = 2'b10
   } svc_state_e;
endpackage

// >>> core/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
   import sysctl_pkg::*;
#(
   parameter int WIDTH = SYNC_WIDTH,
   parameter logic [SYNC_WIDTH-1:0] RESET_VAL = SYNC_RESET_VAL
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= RESET_VAL[WIDTH-1:0];
         sync_out <= RESET_VAL[WIDTH-1:0];
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// >>> core/sysctl_pins.sv
`timescale 1ns/10ps
module sysctl_pins
   import sysctl_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic bus_request_n,
   output logic bus_grant_n,
   output logic bus_drive_en,
   output logic mem_hold_pending,
   input wire logic mem_busy,
   input wire logic sdram_access,
   input wire logic reset_pin_n,
   input wire logic host_chip_select_n,
   input wire logic host_busy,
   output logic host_ready_n,
   input wire logic host_data_oe_src,
   output logic host_data_oe,
   input wire logic serial_port_oe_src,
   output logic serial_port_oe,
   input wire logic [IRQ_LINES-1:0] external_irq_in,
   output logic irq_acknowledge,
   output logic [3:0] irq_number,
   output logic second_clock_out,
   input wire logic [3:0] dma_activity_src,
   output logic [3:0] dma_activity,
   input wire logic power_down_src,
   output logic power_down_flag,
   input wire logic timer0_src,
   output logic timer0_out,
   input wire logic timer1_src,
   output logic timer1_out,
   input wire logic host_irq_src,
   output logic host_irq_out
);
   logic [SYNC_WIDTH-1:0] pins_s;
   logic req_n_s;
   logic dev_rst_reg;
   logic strap_cs_reg;
   logic hold_disable_reg;
   logic burst_retain_reg;
   logic ack_reg;
   hold_state_e hold_state_reg;
   logic [3:0] hold_cnt_reg;
   logic [3:0] burst_cnt_reg;
   logic burst_latch_reg;
   logic [IRQ_LINES-1:0] irq_prev_reg;
   logic [IRQ_LINES-1:0] irq_pend_reg;
   logic [IRQ_LINES-1:0] irq_clear;
   svc_state_e svc_state_reg;
   logic [3:0] svc_cnt_reg;
   logic [1:0] svc_line_reg;
   logic [1:0] pick_line;
   logic clk2_fall;

   pin_sync u_sync (
      .clock(clock),
      .resetn(resetn),
      .async_in({external_irq_in, host_chip_select_n, reset_pin_n, bus_request_n}),
      .sync_out(pins_s)
   );

   assign req_n_s = pins_s[SYNC_HOLD_BIT];

   // device reset follows the synced pin, so it lags the pin by three edges
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dev_rst_reg <= 1'b1;
      end else begin
         dev_rst_reg <= ~pins_s[SYNC_RESET_BIT];
      end
   end

   // chip select is caught while the device sits in reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         strap_cs_reg <= 1'b1;
      end else if (dev_rst_reg) begin
         strap_cs_reg <= pins_s[SYNC_CS_BIT];
      end
   end

   // register slave: one wait cycle, answer on the second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hold_disable_reg <= CTRL_HOLD_DISABLE_RESET;
         burst_retain_reg <= CTRL_BURST_RETAIN_RESET;
      end else if (avs_write && ack_reg && avs_address == CTRL_OFFSET && avs_byteenable[0]) begin
         hold_disable_reg <= avs_writedata[CTRL_HOLD_DISABLE_BIT];
         burst_retain_reg <= avs_writedata[CTRL_BURST_RETAIN_BIT];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_reg) begin
         avs_readdata <= 32'h0000_0000;
         unique case (avs_address)
            CTRL_OFFSET: begin
               avs_readdata[CTRL_HOLD_DISABLE_BIT] <= hold_disable_reg;
               avs_readdata[CTRL_BURST_RETAIN_BIT] <= burst_retain_reg;
            end
            STATUS_OFFSET: begin
               avs_readdata[STATUS_GRANTED_BIT] <= ~bus_grant_n;
               avs_readdata[STATUS_FLOATED_BIT] <= ~bus_drive_en;
               avs_readdata[STATUS_REQUEST_BIT] <= ~req_n_s;
               avs_readdata[STATUS_IN_RESET_BIT] <= dev_rst_reg;
               avs_readdata[STATUS_STRAP_BIT] <= strap_cs_reg;
               avs_readdata[STATUS_IRQ_NUM_LSB +: 4] <= irq_number;
            end
            PENDING_OFFSET: begin
               avs_readdata[IRQ_LINES-1:0] <= irq_pend_reg;
            end
            default: begin
               avs_readdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // bus hold sequencer; every change lands on a rising edge
   assign mem_hold_pending = (hold_state_reg == HOLD_DRAIN);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hold_state_reg <= HOLD_IDLE;
         hold_cnt_reg <= 4'h0;
         burst_cnt_reg <= 4'h0;
         burst_latch_reg <= 1'b0;
         bus_drive_en <= 1'b0;
         bus_grant_n <= 1'b1;
      end else if (dev_rst_reg) begin
         hold_state_reg <= HOLD_IDLE;
         hold_cnt_reg <= 4'h0;
         burst_cnt_reg <= 4'h0;
         burst_latch_reg <= 1'b0;
         bus_drive_en <= 1'b0;
         bus_grant_n <= 1'b1;
      end else begin
         unique case (hold_state_reg)
            HOLD_IDLE: begin
               bus_drive_en <= 1'b1;
               bus_grant_n <= 1'b1;
               if (!req_n_s && !hold_disable_reg) begin
                  hold_state_reg <= HOLD_DRAIN;
                  hold_cnt_reg <= 4'h1;
                  burst_cnt_reg <= {3'h0, sdram_access};
                  burst_latch_reg <= burst_retain_reg & sdram_access;
               end
            end
            HOLD_DRAIN: begin
               if (hold_cnt_reg != 4'hf) begin
                  hold_cnt_reg <= hold_cnt_reg + 4'h1;
               end
               if (sdram_access && burst_cnt_reg != 4'hf) begin
                  burst_cnt_reg <= burst_cnt_reg + 4'h1;
               end
               if (req_n_s || hold_disable_reg) begin
                  hold_state_reg <= HOLD_IDLE;
               end else if (hold_cnt_reg >= HOLD_FLOAT_CYC && !mem_busy
                     && (!burst_latch_reg || burst_cnt_reg >= BURST_RETAIN_COUNT)) begin
                  hold_state_reg <= HOLD_FLOAT;
                  bus_drive_en <= 1'b0;
               end
            end
            HOLD_FLOAT: begin
               hold_state_reg <= HOLD_GRANTED;
               bus_grant_n <= 1'b0;
            end
            HOLD_GRANTED: begin
               if (req_n_s) begin
                  hold_state_reg <= HOLD_RELEASE;
                  hold_cnt_reg <= 4'h1;
               end
            end
            HOLD_RELEASE: begin
               hold_cnt_reg <= hold_cnt_reg + 4'h1;
               if (hold_cnt_reg == RELEASE_DRIVE_CYC - 4'h1) begin
                  bus_drive_en <= 1'b1;
               end
               if (hold_cnt_reg == RELEASE_GRANT_CYC - 4'h1) begin
                  bus_grant_n <= 1'b1;
                  hold_state_reg <= HOLD_IDLE;
               end
            end
            default: begin
               hold_state_reg <= HOLD_IDLE;
            end
         endcase
      end
   end

   // second clock runs at half rate
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         second_clock_out <= 1'b0;
      end else begin
         second_clock_out <= ~second_clock_out;
      end
   end

   assign clk2_fall = second_clock_out;

   // a new edge wins over a clear in the same cycle
   generate
      for (genvar i = 0; i < IRQ_LINES; i++) begin : g_irq
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               irq_prev_reg[i] <= 1'b0;
               irq_pend_reg[i] <= 1'b0;
            end else begin
               irq_prev_reg[i] <= pins_s[SYNC_IRQ_LSB + i];
               if (dev_rst_reg) begin
                  irq_pend_reg[i] <= 1'b0;
               end else if (pins_s[SYNC_IRQ_LSB + i] && !irq_prev_reg[i]) begin
                  irq_pend_reg[i] <= 1'b1;
               end else if (irq_clear[i]) begin
                  irq_pend_reg[i] <= 1'b0;
               end
            end
         end
         assign irq_clear[i] = (svc_state_reg == SVC_ACK) && clk2_fall
            && (svc_line_reg == 2'(i));
      end
   endgenerate

   always_comb begin
      pick_line = 2'h0;
      for (int j = IRQ_LINES - 1; j >= 0; j--) begin
         if (irq_pend_reg[j]) begin
            pick_line = 2'(j);
         end
      end
   end

   // acknowledge engine; lowest pending line first
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         svc_state_reg <= SVC_IDLE;
         svc_cnt_reg <= 4'h0;
         svc_line_reg <= 2'h0;
         irq_acknowledge <= 1'b0;
         irq_number <= 4'h0;
      end else if (dev_rst_reg) begin
         svc_state_reg <= SVC_IDLE;
         svc_cnt_reg <= 4'h0;
         irq_acknowledge <= 1'b0;
         irq_number <= 4'h0;
      end else begin
         unique case (svc_state_reg)
            SVC_IDLE: begin
               if (|irq_pend_reg) begin
                  svc_state_reg <= SVC_WAIT;
                  svc_line_reg <= pick_line;
                  svc_cnt_reg <= 4'h1;
               end
            end
            SVC_WAIT: begin
               if (svc_cnt_reg != 4'hf) begin
                  svc_cnt_reg <= svc_cnt_reg + 4'h1;
               end
               if (svc_cnt_reg >= IRQ_ACKNOWLEDGE_MIN_CYC && clk2_fall) begin
                  svc_state_reg <= SVC_ACK;
                  irq_acknowledge <= 1'b1;
                  irq_number <= IRQ_NUM_BASE + {2'h0, svc_line_reg};
               end
            end
            SVC_ACK: begin
               if (clk2_fall) begin
                  svc_state_reg <= SVC_IDLE;
                  irq_acknowledge <= 1'b0;
                  irq_number <= 4'h0;
               end
            end
            default: begin
               svc_state_reg <= SVC_IDLE;
            end
         endcase
      end
   end

   // pin groups held at their reset levels while the device is in reset; host ready follows the select
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dma_activity <= 4'h0;
         power_down_flag <= 1'b0;
         timer0_out <= 1'b0;
         timer1_out <= 1'b0;
         host_irq_out <= 1'b1;
         host_data_oe <= 1'b0;
         serial_port_oe <= 1'b0;
         host_ready_n <= 1'b0;
      end else if (dev_rst_reg) begin
         dma_activity <= 4'h0;
         power_down_flag <= 1'b0;
         timer0_out <= 1'b0;
         timer1_out <= 1'b0;
         host_irq_out <= 1'b1;
         host_data_oe <= 1'b0;
         serial_port_oe <= 1'b0;
         // live select, so the level agrees with the catch made on this same edge
         host_ready_n <= ~pins_s[SYNC_CS_BIT];
      end else begin
         dma_activity <= dma_activity_src;
         power_down_flag <= power_down_src;
         timer0_out <= timer0_src;
         timer1_out <= timer1_src;
         host_irq_out <= host_irq_src;
         host_data_oe <= host_data_oe_src;
         serial_port_oe <= serial_port_oe_src;
         // ready is forced low whenever the host is not selected
         host_ready_n <= ~pins_s[SYNC_CS_BIT] & host_busy;
      end
   end

   property p_float_min;
      @(posedge clock) disable iff (!resetn)
      ($fell(req_n_s) && hold_state_reg == HOLD_IDLE && !dev_rst_reg) |-> bus_drive_en[*4];
   endproperty
   a_float_min: assert property (p_float_min) else $error("bus floated too early");

   property p_grant_after_float;
      @(posedge clock) disable iff (!resetn)
      ($fell(bus_drive_en) && !dev_rst_reg && !$past(dev_rst_reg)) |-> ##[1:2] !bus_grant_n;
   endproperty
   a_grant_after_float: assert property (p_grant_after_float) else $error("grant late");

   property p_grant_release;
      @(posedge clock) disable iff (!resetn || dev_rst_reg)
      ($rose(req_n_s) && hold_state_reg == HOLD_GRANTED) |->
         !bus_grant_n[*2] ##[1:3] bus_grant_n;
   endproperty
   a_grant_release: assert property (p_grant_release) else $error("grant release timing");

   property p_drive_release;
      @(posedge clock) disable iff (!resetn || dev_rst_reg)
      ($rose(req_n_s) && hold_state_reg == HOLD_GRANTED) |-> !bus_drive_en ##[1:4] bus_drive_en;
   endproperty
   a_drive_release: assert property (p_drive_release) else $error("bus drive resume timing");

   property p_drain_first;
      @(posedge clock) disable iff (!resetn)
      ($fell(bus_drive_en) && hold_state_reg == HOLD_FLOAT) |-> !$past(mem_busy);
   endproperty
   a_drain_first: assert property (p_drain_first) else $error("floated during transfer");

   property p_hold_disable;
      @(posedge clock) disable iff (!resetn)
      (hold_disable_reg && hold_state_reg == HOLD_IDLE) |=> hold_state_reg == HOLD_IDLE;
   endproperty
   a_hold_disable: assert property (p_hold_disable) else $error("hold taken while disabled");

   property p_burst_retain;
      @(posedge clock) disable iff (!resetn)
      (hold_state_reg == HOLD_FLOAT && burst_latch_reg) |-> burst_cnt_reg >= 4'h8;
   endproperty
   a_burst_retain: assert property (p_burst_retain) else $error("burst cut short");

   property p_granted_floats;
      @(posedge clock) disable iff (!resetn)
      // release lets the bus be driven again one edge before grant returns high
      (!bus_grant_n && hold_state_reg == HOLD_GRANTED) |-> !bus_drive_en;
   endproperty
   a_granted_floats: assert property (p_granted_floats) else $error("bus driven while granted");

   property p_reset_response;
      @(posedge clock) disable iff (!resetn)
      $rose(dev_rst_reg) |-> !$past(reset_pin_n, 3);
   endproperty
   a_reset_response: assert property (p_reset_response) else $error("reset seen too soon");

   property p_reset_groups;
      @(posedge clock) disable iff (!resetn)
      (dev_rst_reg && $past(dev_rst_reg)) |-> (irq_number == 4'h0 && !irq_acknowledge
         && dma_activity == 4'h0 && !timer0_out && host_irq_out && !host_data_oe
         && !bus_drive_en && host_ready_n == ~strap_cs_reg);
   endproperty
   a_reset_groups: assert property (p_reset_groups) else $error("reset pin groups wrong");

   property p_irq_acknowledge_latency;
      @(posedge clock) disable iff (!resetn)
      $rose(irq_acknowledge) |-> $past(svc_cnt_reg) >= 4'h9 && $fell(second_clock_out);
   endproperty
   a_irq_acknowledge_latency: assert property (p_irq_acknowledge_latency) else $error("acknowledge too early");

   property p_irq_acknowledge_number;
      @(posedge clock) disable iff (!resetn)
      irq_acknowledge |-> irq_number == IRQ_NUM_BASE + {2'h0, svc_line_reg};
   endproperty
   a_irq_acknowledge_number: assert property (p_irq_acknowledge_number) else $error("wrong interrupt number");

   c_grant: cover property (@(posedge clock) disable iff (!resetn) $fell(bus_grant_n));
   c_burst: cover property (@(posedge clock) disable iff (!resetn)
      hold_state_reg == HOLD_FLOAT && burst_latch_reg);
   c_irq_acknowledge: cover property (@(posedge clock) disable iff (!resetn) $rose(irq_acknowledge));
   c_reset: cover property (@(posedge clock) disable iff (!resetn) $fell(dev_rst_reg));
endmodule

// >>> bench/hold_requester.sv
`timescale 1ns/10ps
module hold_requester (
   input wire logic clock,
   input wire logic resetn,
   input wire logic want,
   input wire logic bus_grant_n,
   output logic bus_request_n
);
   // no fresh request while the previous grant is still low
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus_request_n <= 1'b1;
      end else if (!want) begin
         bus_request_n <= 1'b1;
      end else if (bus_grant_n) begin
         bus_request_n <= 1'b0;
      end
   end
endmodule

// >>> bench/test_bus_hold_reset_irq_pins.sv
`timescale 1ns/10ps
module test_bus_hold_reset_irq_pins
   import sysctl_pkg::*;
;
   logic clock = 1'b0;
   logic resetn, avs_read, avs_write, avs_waitrequest, want;
   logic [3:0] avs_address, avs_byteenable, irq_number, external_irq_in;
   logic [3:0] dma_activity_src, dma_activity;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic bus_request_n, bus_grant_n, bus_drive_en, mem_hold_pending, mem_busy;
   logic sdram_access, reset_pin_n, host_chip_select_n, host_busy, host_ready_n;
   logic host_data_oe_src, host_data_oe, serial_port_oe_src, serial_port_oe;
   logic irq_acknowledge, second_clock_out, power_down_src, power_down_flag;
   logic timer0_src, timer0_out, timer1_src, timer1_out, host_irq_src, host_irq_out;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   int n, m;
   localparam int PLL_LOCK_CYCLES = 250000 / CLOCK_PERIOD_NS;

   sysctl_pins i_dut (.clock, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_request_n, .bus_grant_n,
      .bus_drive_en, .mem_hold_pending, .mem_busy, .sdram_access, .reset_pin_n,
      .host_chip_select_n, .host_busy, .host_ready_n, .host_data_oe_src, .host_data_oe,
      .serial_port_oe_src, .serial_port_oe, .external_irq_in, .irq_acknowledge,
      .irq_number, .second_clock_out, .dma_activity_src, .dma_activity, .power_down_src,
      .power_down_flag, .timer0_src, .timer0_out, .timer1_src, .timer1_out,
      .host_irq_src, .host_irq_out);

   hold_requester i_master (.clock, .resetn, .want, .bus_grant_n, .bus_request_n);

   always #5 clock = ~clock;

   // lock-time pin reset plus a few hundred cycles; generous ceiling
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         end_of_test();
      end
   end

   task end_of_test;
      if (n_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task in_range(input string what, input int v, input int lo, input int hi);
      compares++;
      if (v < lo || v > hi) begin
         n_errors++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, v);
      end
   endtask

   function automatic logic pick(input int k);
      case (k)
         0: return bus_drive_en;
         1: return bus_grant_n;
         2: return irq_acknowledge;
         default: return timer0_out;
      endcase
   endfunction

   // counts edges until the picked output shows v, sampled just after each edge
   task wait_for(input int k, input logic v, output int cnt);
      cnt = 0;
      while (pick(k) !== v && cnt < 300) begin
         @(posedge clock);
         #1;
         cnt++;
      end
   endtask

   // request stands until waitrequest is seen low at a rising edge; data taken there
   task access(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= 4'hf;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task reset_groups(input logic rdy);
      check("low group", 0, {irq_acknowledge, irq_number, dma_activity, power_down_flag,
         timer0_out, timer1_out});
      check("host irq", 1, host_irq_out);
      check("float group", 0, {bus_drive_en, host_data_oe, serial_port_oe});
      check("host ready", rdy, host_ready_n);
   endtask

   task hold(input int lo, input int hi);
      @(posedge clock);
      want <= 1'b1;
      @(posedge clock);
      #1;
      wait_for(0, 1'b0, n);
      in_range("float delay", n, lo, hi);
      wait_for(1, 1'b0, m);
      in_range("grant delay", m, 1, 2);
      repeat (3) @(posedge clock);
      #1;
      check("bus drive while granted", 0, bus_drive_en);
      @(posedge clock);
      want <= 1'b0;
      @(posedge clock);
      #1;
      wait_for(0, 1'b1, n);
      in_range("redrive delay", n, 3, 6);
      wait_for(1, 1'b1, m);
      in_range("grant release delay", n + m, 4, 7);
   endtask

   initial begin
      resetn = 1'b0;
      want = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
      {mem_busy, sdram_access, host_busy, host_irq_src, external_irq_in} = '0;
      {reset_pin_n, host_chip_select_n, host_data_oe_src, serial_port_oe_src} = 4'h7;
      {dma_activity_src, power_down_src, timer0_src, timer1_src} = 7'h7f;
      repeat (5) @(posedge clock);
      #1;
      reset_groups(1'b0);
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      // device reset pin stays low long enough for a multiplying clock to lock
      repeat (PLL_LOCK_CYCLES) @(posedge clock);
      #1;
      reset_groups(1'b0);
      @(posedge clock);
      reset_pin_n <= 1'b1;
      access(1'b0, CTRL_OFFSET, 0);
      check("ctrl reset", 0, rd);
      access(1'b1, 4'hc, 32'hffffffff);
      access(1'b0, 4'hc, 0);
      check("unmapped read", 0, rd);
      hold(4, 12);
      @(posedge clock);
      mem_busy <= 1'b1;
      fork
         hold(14, 40);
         begin
            repeat (14) @(posedge clock);
            #1;
            check("hold pending", 1, mem_hold_pending);
            @(posedge clock);
            mem_busy <= 1'b0;
         end
      join
      access(1'b1, CTRL_OFFSET, 32'h2);
      sdram_access <= 1'b1;
      fork
         hold(9, 40);
         begin
            repeat (12) @(posedge clock);
            sdram_access <= 1'b0;
         end
      join
      access(1'b1, CTRL_OFFSET, 32'h1);
      @(posedge clock);
      want <= 1'b1;
      repeat (30) @(posedge clock);
      #1;
      check("disabled hold", 2'b11, {bus_grant_n, bus_drive_en});
      access(1'b0, STATUS_OFFSET, 0);
      check("status", (1 << STATUS_REQUEST_BIT) | (1 << STATUS_STRAP_BIT), rd);
      @(posedge clock);
      want <= 1'b0;
      access(1'b1, CTRL_OFFSET, 32'h0);
      // two lines at once: lowest served first
      @(posedge clock);
      external_irq_in <= 4'h5;
      #1;
      fork
         begin
            repeat (3) @(posedge clock);
            external_irq_in <= 4'h0;
         end
      join_none
      wait_for(2, 1'b1, n);
      in_range("ack delay", n, 9, 40);
      check("second clock at ack", 0, second_clock_out);
      check("irq number", IRQ_NUM_BASE, irq_number);
      wait_for(2, 1'b0, n);
      wait_for(2, 1'b1, n);
      check("second irq number", IRQ_NUM_BASE + 4'h2, irq_number);
      for (int cs = 1; cs >= 0; cs--) begin
         @(posedge clock);
         host_chip_select_n <= cs[0];
         repeat (4) @(posedge clock);
         reset_pin_n <= 1'b0;
         repeat (2) @(posedge clock);
         #1;
         check("output before reset response", 1, timer0_out);
         wait_for(3, 1'b0, n);
         reset_groups(!cs[0]);
         repeat (6) @(posedge clock);
         reset_pin_n <= 1'b1;
         repeat (8) @(posedge clock);
      end
      end_of_test();
   end
endmodule
